/* File: pkg/ebawc_pkg.sv */
// Package of constants and carrier types for the external bus area wait control block
package ebawc_pkg;

  // Register byte addresses on the register bus
  localparam logic [3:0]  BUS_AREA_CONFIG_ADDR   = 4'h0;
  localparam logic [3:0]  WAIT_STATE_SELECT_ADDR = 4'h4;
  localparam logic [3:0]  LONG_WAIT_CTRL_ADDR    = 4'h8;
  localparam logic [3:0]  ACCESS_STATUS_ADDR     = 4'hc;

  // Field positions
  localparam int DYN_MEM_BIT     = 15;
  localparam int MUX_IO_BIT      = 14;
  localparam int OVERLAP_BIT     = 13;
  localparam int RD_DUTY_BIT     = 12;
  localparam int BYTE_SCHEME_BIT = 11;
  localparam int READ_WAIT_LSB   = 8;
  localparam int WRITE_WAIT_BIT  = 1;
  localparam int A02_LW_LSB      = 13;
  localparam int A6_LW_LSB       = 11;
  localparam int REF_LW_LSB      = 0;

  // Reset values and writable masks
  localparam logic [15:0] BUS_AREA_CONFIG_RST   = 16'h0000;
  localparam logic [15:0] BUS_AREA_CONFIG_MASK  = 16'hf800;
  localparam logic [15:0] WAIT_STATE_SELECT_RST = 16'hffff;
  localparam logic [15:0] WAIT_STATE_SELECT_WR  = 16'hff02;
  localparam logic [15:0] LONG_WAIT_CTRL_RST    = 16'h7803;
  localparam logic [15:0] LONG_WAIT_CTRL_MASK   = 16'h7803;

  // Cycle counts
  localparam logic [3:0] FIXED_ONE_CYCLES   = 4'h1;
  localparam logic [3:0] SAMPLED_MIN_CYCLES = 4'h2;
  localparam logic [3:0] MUX_IO_CYCLES      = 4'h4;
  localparam logic [3:0] RD_PERIOD_CYCLES   = 4'h1;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SPACE_MEMORY, SPACE_DRAM, SPACE_MUX_IO} ebawc_space_e;

  typedef struct packed {
    logic       valid;
    logic [2:0] area;
    logic       write;
    logic       refresh;
    logic       internal_busy;
  } ebawc_req_s;

  typedef struct packed {
    logic [1:0] space;
    logic       rd_duty_35;
    logic       byte_scheme;
    logic       overlap;
  } ebawc_cfg_s;

endpackage : ebawc_pkg

/* File: verilog/ebawc_wait_timer.sv */
// Wait-state counter that stretches one external access
`timescale 1ns/10ps
module ebawc_wait_timer
  import ebawc_pkg::*;
(
  input  wire logic       MCLK_IN,      // System clock
  input  wire logic       RST_N_IN,     // Sync reset, active low
  input  wire logic       start_in,     // Start pulse
  input  wire logic [3:0] base_in,      // Base cycle count
  input  wire logic       sample_in,    // Wait pin honoured
  input  wire logic       wait_in,      // External wait request
  output logic            busy_out,     // Access in progress
  output logic            done_out      // Pulse in the cycle after the last busy cycle
);
  import ebawc_pkg::*;

  logic [3:0] cnt_q, cnt_d;
  logic       busy_q, busy_d;
  logic       samp_q, samp_d;
  logic       done_q, done_d;

  always_comb
  begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    samp_d = samp_q;
    done_d = 1'b0;
    if (!busy_q && start_in)
    begin
      cnt_d  = base_in;
      busy_d = 1'b1;
      samp_d = sample_in;
    end
    else if (busy_q)
    begin
      // Wait pin holds the final count only when sampling is enabled
      if (cnt_q > 4'h1)
        cnt_d = cnt_q - 4'h1;
      else if (!(samp_q && wait_in))
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_N_IN)
    begin
      cnt_q  <= 4'h0;
      busy_q <= 1'b0;
      samp_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      samp_q <= samp_d;
      done_q <= done_d;
    end
  end

  assign busy_out = busy_q;
  assign done_out = done_q;

endmodule : ebawc_wait_timer

/* File: verilog/ebawc_top.sv */
// Area configuration, strobe scheme and wait-state control with AXI4-Lite registers
`timescale 1ns/10ps
module ebawc_top
  import ebawc_pkg::*;
(
  input  wire logic              MCLK_IN,           // System clock, 200 MHz
  input  wire logic              RST_N_IN,          // Sync reset, active low
  input  wire logic [3:0]        S_AWADDR_IN,       // Write address
  input  wire logic              S_AWVALID_IN,      // Write address valid
  output logic                   S_AWREADY_OUT,     // Write address ready
  input  wire logic [31:0]       S_WDATA_IN,        // Write data
  input  wire logic [3:0]        S_WSTRB_IN,        // Write byte strobes
  input  wire logic              S_WVALID_IN,       // Write data valid
  output logic                   S_WREADY_OUT,      // Write data ready
  output logic [1:0]             S_BRESP_OUT,       // Write response
  output logic                   S_BVALID_OUT,      // Write response valid
  input  wire logic              S_BREADY_IN,       // Write response ready
  input  wire logic [3:0]        S_ARADDR_IN,       // Read address
  input  wire logic              S_ARVALID_IN,      // Read address valid
  output logic                   S_ARREADY_OUT,     // Read address ready
  output logic [31:0]            S_RDATA_OUT,       // Read data
  output logic [1:0]             S_RRESP_OUT,       // Read response
  output logic                   S_RVALID_OUT,      // Read data valid
  input  wire logic              S_RREADY_IN,       // Read data ready
  input  wire ebawc_pkg::ebawc_req_s REQ_IN,        // External access request
  output logic                   REQ_READY_OUT,     // Request accepted
  output logic                   ACC_DONE_OUT,      // Access completed pulse
  input  wire logic              WAIT_N_IN,         // External wait pin, active low
  output ebawc_pkg::ebawc_cfg_s  CFG_OUT,           // Decoded area configuration
  output logic                   RD_N_OUT,          // Read strobe, active low
  output logic                   WR_HIGH_N_OUT,     // High byte write or single strobe
  output logic                   WR_LOW_N_OUT,      // Low byte write strobe
  output logic                   HIGH_BYTE_N_OUT,   // High byte strobe
  output logic                   LOW_BYTE_N_OUT,    // Low byte strobe or A0
  input  wire logic              ADDR0_IN,          // Byte address bit 0
  input  wire logic              WORD_IN            // Word-wide write
);
  import ebawc_pkg::*;

  function automatic logic [3:0] lw_cycles(input logic [1:0] sel);
    lw_cycles = {2'b00, sel} + 4'h1;
  endfunction : lw_cycles

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] st, input logic [15:0] msk);
    logic [15:0] nv;
    nv = old;
    if (st[0])
      nv[7:0] = wd[7:0];
    if (st[1])
      nv[15:8] = wd[15:8];
    merge = (nv & msk) | (old & ~msk);
  endfunction : merge

  // Register bus state
  logic [15:0] bac_q, bac_d, wss_q, wss_d, lwc_q, lwc_d;
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [3:0]  aw_addr_q, aw_addr_d, w_strb_q, w_strb_d;
  logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;

  // Access state
  ebawc_req_s  cur_q, cur_d;
  logic [3:0]  base;
  logic        sample, tmr_busy, start;
  logic        rd_phase_q, rd_phase_d;
  logic [1:0]  rd_cnt_q, rd_cnt_d;

  always_comb
  begin
    bac_d     = bac_q;
    wss_d     = wss_q;
    lwc_d     = lwc_q;
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    aw_addr_d = aw_addr_q;
    w_strb_d  = w_strb_q;
    w_data_d  = w_data_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (S_AWVALID_IN && !aw_have_q)
    begin
      aw_have_d = 1'b1;
      aw_addr_d = S_AWADDR_IN;
    end
    if (S_WVALID_IN && !w_have_q)
    begin
      w_have_d = 1'b1;
      w_data_d = S_WDATA_IN;
      w_strb_d = S_WSTRB_IN;
    end
    if (aw_have_q && w_have_q && !bvalid_q)
    begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      unique case (aw_addr_q)
        BUS_AREA_CONFIG_ADDR:
          bac_d = merge(bac_q, w_data_q, w_strb_q, BUS_AREA_CONFIG_MASK);
        // Clearing area 1 write wait while area 1 is plain memory is the
        // caller's fault; hardware stores it and the timer still applies it to area 1 writes there
        WAIT_STATE_SELECT_ADDR:
          wss_d = merge(wss_q, w_data_q, w_strb_q, WAIT_STATE_SELECT_WR);
        LONG_WAIT_CTRL_ADDR:
          lwc_d = merge(lwc_q, w_data_q, w_strb_q, LONG_WAIT_CTRL_MASK);
        ACCESS_STATUS_ADDR:
          bresp_d = RESP_OKAY;
        default:
          bresp_d = RESP_SLVERR;
      endcase
    end
    else if (bvalid_q && S_BREADY_IN)
      bvalid_d = 1'b0;
    if (S_ARVALID_IN && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      unique case (S_ARADDR_IN)
        BUS_AREA_CONFIG_ADDR:   rdata_d = {16'h0000, bac_q};
        WAIT_STATE_SELECT_ADDR: rdata_d = {16'h0000, wss_q};
        LONG_WAIT_CTRL_ADDR:    rdata_d = {16'h0000, lwc_q};
        ACCESS_STATUS_ADDR:     rdata_d = {24'h000000, 5'h00, cur_q.area};
        default:
        begin
          rdata_d = 32'h00000000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && S_RREADY_IN)
      rvalid_d = 1'b0;
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_N_IN)
    begin
      bac_q     <= BUS_AREA_CONFIG_RST;
      wss_q     <= WAIT_STATE_SELECT_RST;
      lwc_q     <= LONG_WAIT_CTRL_RST;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 4'h0;
      w_strb_q  <= 4'h0;
      w_data_q  <= 32'h00000000;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h00000000;
    end
    else
    begin
      bac_q     <= bac_d;
      wss_q     <= wss_d;
      lwc_q     <= lwc_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      aw_addr_q <= aw_addr_d;
      w_strb_q  <= w_strb_d;
      w_data_q  <= w_data_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  assign S_AWREADY_OUT = !aw_have_q;
  assign S_WREADY_OUT  = !w_have_q;
  assign S_BVALID_OUT  = bvalid_q;
  assign S_BRESP_OUT   = bresp_q;
  assign S_ARREADY_OUT = !rvalid_q;
  assign S_RVALID_OUT  = rvalid_q;
  assign S_RRESP_OUT   = rresp_q;
  assign S_RDATA_OUT   = rdata_q;

  // Space of the requested area
  ebawc_space_e space;
  logic         rw_bit;
  always_comb
  begin
    space = SPACE_MEMORY;
    if (REQ_IN.area == 3'h1 && bac_q[DYN_MEM_BIT])
      space = SPACE_DRAM;
    else if (REQ_IN.area == 3'h6 && bac_q[MUX_IO_BIT])
      space = SPACE_MUX_IO;
    rw_bit = wss_q[READ_WAIT_LSB + 32'(REQ_IN.area)];
    base   = FIXED_ONE_CYCLES;
    sample = 1'b0;
    if (REQ_IN.refresh)
      base = lw_cycles(lwc_q[REF_LW_LSB +: 2]);
    else if (space == SPACE_MUX_IO)
    begin
      base   = MUX_IO_CYCLES;
      sample = 1'b1;
    end
    else if (space == SPACE_DRAM)
    begin
      // Column cycle pitch: writes use area 1 write wait, reads the read wait bit
      sample = REQ_IN.write ? wss_q[WRITE_WAIT_BIT] : rw_bit;
      base   = sample ? SAMPLED_MIN_CYCLES : FIXED_ONE_CYCLES;
    end
    else if (REQ_IN.area == 3'h0 || REQ_IN.area == 3'h2 || REQ_IN.area == 3'h6)
    begin
      base = FIXED_ONE_CYCLES + ((REQ_IN.area == 3'h6) ? lw_cycles(lwc_q[A6_LW_LSB +: 2])
                                 : lw_cycles(lwc_q[A02_LW_LSB +: 2]));
      sample = REQ_IN.write ? 1'b0 : rw_bit;
    end
    else if (!REQ_IN.write && rw_bit)
    begin
      base   = SAMPLED_MIN_CYCLES;
      sample = 1'b1;
    end
    else if (REQ_IN.write && REQ_IN.area == 3'h1)
    begin
      sample = wss_q[WRITE_WAIT_BIT];
      base   = sample ? SAMPLED_MIN_CYCLES : FIXED_ONE_CYCLES;
    end
  end

  // Without overlap, an external access waits until internal traffic is idle
  assign REQ_READY_OUT = !tmr_busy && (bac_q[OVERLAP_BIT] || !REQ_IN.internal_busy);
  assign start = REQ_IN.valid && REQ_READY_OUT;

  ebawc_wait_timer u_timer (
    .MCLK_IN   (MCLK_IN),
    .RST_N_IN  (RST_N_IN),
    .start_in  (start),
    .base_in   (base),
    .sample_in (sample && !REQ_IN.refresh),
    .wait_in   (!WAIT_N_IN),
    .busy_out  (tmr_busy),
    .done_out  (ACC_DONE_OUT)
  );

  // Strobe phase: read strobe high for the last part of each four-cycle count period
  always_comb
  begin
    cur_d      = start ? REQ_IN : cur_q;
    rd_cnt_d   = tmr_busy ? rd_cnt_q + 2'h1 : 2'h0;
    // 35% duty raises the strobe one quarter later than 50%
    rd_phase_d = tmr_busy && !cur_q.write && !cur_q.refresh &&
                 (bac_q[RD_DUTY_BIT] ? (rd_cnt_q != 2'h3) : !rd_cnt_q[1]);
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_N_IN)
    begin
      cur_q      <= '0;
      rd_cnt_q   <= 2'h0;
      rd_phase_q <= 1'b0;
    end
    else
    begin
      cur_q      <= cur_d;
      rd_cnt_q   <= rd_cnt_d;
      rd_phase_q <= rd_phase_d;
    end
  end

  logic wr_act;
  assign wr_act   = tmr_busy && cur_q.write && !cur_q.refresh;
  assign RD_N_OUT = !rd_phase_q;

  always_comb
  begin
    if (bac_q[BYTE_SCHEME_BIT])
    begin
      WR_HIGH_N_OUT   = !wr_act;
      WR_LOW_N_OUT    = 1'b1;
      HIGH_BYTE_N_OUT = !(tmr_busy && (WORD_IN || !ADDR0_IN));
      LOW_BYTE_N_OUT  = !(tmr_busy && (WORD_IN || ADDR0_IN));
    end
    else
    begin
      WR_HIGH_N_OUT   = !(wr_act && (WORD_IN || !ADDR0_IN));
      WR_LOW_N_OUT    = !(wr_act && (WORD_IN || ADDR0_IN));
      HIGH_BYTE_N_OUT = 1'b1;
      LOW_BYTE_N_OUT  = ADDR0_IN;
    end
  end

  assign CFG_OUT = '{space: 2'(space), rd_duty_35: bac_q[RD_DUTY_BIT],
                     byte_scheme: bac_q[BYTE_SCHEME_BIT], overlap: bac_q[OVERLAP_BIT]};

endmodule : ebawc_top

/* File: sim/ebawc_ext_dev.sv */
// External device model that stretches accesses through the wait pin
`timescale 1ns/10ps
module ebawc_ext_dev
(
  input  wire logic       clk_in,     // System clock
  input  wire logic       rst_n_in,   // Sync reset, active low
  input  wire logic       take_in,    // Access taken by the block
  input  wire logic [3:0] stall_in,   // Wait cycles to request
  output logic            wait_n_out  // Wait pin, active low
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (take_in)
      cnt_d = stall_in;
    else if (cnt_q != 4'h0)
      cnt_d = cnt_q - 4'h1;
  end

  always_ff @(posedge clk_in)
    cnt_q <= rst_n_in ? cnt_d : 4'h0;

  // Pulled-up pin, so it idles high between stalls
  assign wait_n_out = (cnt_q == 4'h0);
endmodule : ebawc_ext_dev

/* File: sim/ebawc_chk.sv */
// Concurrent checks on the access port and register bus
`timescale 1ns/10ps
module ebawc_chk
  import ebawc_pkg::*;
(
  input wire logic                  MCLK_IN,       // System clock
  input wire logic                  RST_N_IN,      // Sync reset, active low
  input wire ebawc_pkg::ebawc_req_s REQ_IN,        // Access request
  input wire logic                  REQ_READY_OUT, // Request accepted
  input wire logic                  ACC_DONE_OUT,  // Access done pulse
  input wire ebawc_pkg::ebawc_cfg_s CFG_OUT,       // Decoded configuration
  input wire logic                  S_BVALID_OUT,  // Write response valid
  input wire logic                  S_BREADY_IN,   // Write response ready
  input wire logic [1:0]            S_BRESP_OUT,   // Write response
  input wire logic                  S_RVALID_OUT,  // Read data valid
  input wire logic                  S_RREADY_IN,   // Read data ready
  input wire logic [31:0]           S_RDATA_OUT    // Read data
);
  logic take;

  assign take = REQ_IN.valid && REQ_READY_OUT;

  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  space_fixed_a: assert property (
    !(REQ_IN.area inside {3'h1, 3'h6}) |-> CFG_OUT.space == 2'h0)
    else $error("Fixed memory area decoded as special space");
  overlap_block_a: assert property (
    REQ_IN.valid && REQ_IN.internal_busy && !CFG_OUT.overlap |-> !REQ_READY_OUT)
    else $error("External access taken while internal access busy");
  done_pulse_a: assert property (ACC_DONE_OUT |=> !ACC_DONE_OUT)
    else $error("Done pulse longer than one cycle");
  busy_refuse_a: assert property (take |=> !REQ_READY_OUT && !ACC_DONE_OUT)
    else $error("Access accepted or ended right after a take");
  muxio_len_a: assert property (
    take && !REQ_IN.refresh && CFG_OUT.space == 2'h2 |=> (!ACC_DONE_OUT) [*4])
    else $error("Multiplexed access shorter than four cycles");
  refresh_bound_a: assert property (take && REQ_IN.refresh |-> ##[2:5] ACC_DONE_OUT)
    else $error("Refresh access not ended by its long wait");
  bresp_hold_a: assert property (
    S_BVALID_OUT && !S_BREADY_IN |=> S_BVALID_OUT && $stable(S_BRESP_OUT))
    else $error("Write response dropped before taken");
  rdata_hold_a: assert property (
    S_RVALID_OUT && !S_RREADY_IN |=> S_RVALID_OUT && $stable(S_RDATA_OUT))
    else $error("Read data dropped before taken");
endmodule : ebawc_chk

bind ebawc_top ebawc_chk u_chk
(
  .MCLK_IN       (MCLK_IN),
  .RST_N_IN      (RST_N_IN),
  .REQ_IN        (REQ_IN),
  .REQ_READY_OUT (REQ_READY_OUT),
  .ACC_DONE_OUT  (ACC_DONE_OUT),
  .CFG_OUT       (CFG_OUT),
  .S_BVALID_OUT  (S_BVALID_OUT),
  .S_BREADY_IN   (S_BREADY_IN),
  .S_BRESP_OUT   (S_BRESP_OUT),
  .S_RVALID_OUT  (S_RVALID_OUT),
  .S_RREADY_IN   (S_RREADY_IN),
  .S_RDATA_OUT   (S_RDATA_OUT)
);

/* File: sim/external_bus_area_wait_control_test.sv */
// Self-checking bench for the area configuration and wait-state block
`timescale 1ns/10ps
module external_bus_area_wait_control_test;
  import ebawc_pkg::*;
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic [3:0]  awaddr  = 4'h0;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [3:0]  araddr  = 4'h0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  ebawc_req_s  req     = '0;
  logic        addr0   = 1'b0;
  logic        word    = 1'b1;
  logic [3:0]  stall   = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, req_ready, acc_done, wait_n;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  ebawc_cfg_s  cfg;
  logic        rd_n, wr_hi_n, wr_lo_n, hb_n, lb_n;
  int          n_fail  = 0;
  int          n_tests = 0;
  int          cyc     = 0;
  int          n;

  ebawc_top dut
  (
    .MCLK_IN(clk), .RST_N_IN(rst_n),
    .S_AWADDR_IN(awaddr), .S_AWVALID_IN(awvalid), .S_AWREADY_OUT(awready),
    .S_WDATA_IN(wdata), .S_WSTRB_IN(4'hf), .S_WVALID_IN(wvalid), .S_WREADY_OUT(wready),
    .S_BRESP_OUT(bresp), .S_BVALID_OUT(bvalid), .S_BREADY_IN(bready),
    .S_ARADDR_IN(araddr), .S_ARVALID_IN(arvalid), .S_ARREADY_OUT(arready),
    .S_RDATA_OUT(rdata), .S_RRESP_OUT(rresp), .S_RVALID_OUT(rvalid), .S_RREADY_IN(rready),
    .REQ_IN(req), .REQ_READY_OUT(req_ready), .ACC_DONE_OUT(acc_done),
    .WAIT_N_IN(wait_n), .CFG_OUT(cfg), .RD_N_OUT(rd_n), .WR_HIGH_N_OUT(wr_hi_n),
    .WR_LOW_N_OUT(wr_lo_n), .HIGH_BYTE_N_OUT(hb_n), .LOW_BYTE_N_OUT(lb_n),
    .ADDR0_IN(addr0), .WORD_IN(word)
  );

  ebawc_ext_dev u_dev
  (
    .clk_in(clk), .rst_n_in(rst_n), .take_in(req.valid & req_ready),
    .stall_in(stall), .wait_n_out(wait_n)
  );

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test;
    end
  end

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Response ready is raised late on purpose so the hold of the answer is exercised
  task wr(input logic [3:0] a, input logic [15:0] d);
    awaddr <= a;
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b1;
    @(posedge clk);
    bready <= 1'b0;
    chk("bresp", bresp, RESP_OKAY);
  endtask : wr

  task rd(input logic [3:0] a, input logic [15:0] exp, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b1;
    @(posedge clk);
    rready <= 1'b0;
    chk("rdata", rdata, {16'h0, exp});
    chk("rresp", rresp, er);
  endtask : rd

  // Cycles from the taking edge to the edge at which the done pulse is sampled
  task acc(input logic [2:0] a, input logic w, input logic r, input logic [3:0] s,
           output int cnt);
    @(posedge clk);
    req <= '{1'b1, a, w, r, 1'b0};
    stall <= s;
    do
      @(posedge clk);
    while (req_ready !== 1'b1);
    req.valid <= 1'b0;
    cnt = 0;
    do
    begin
      @(posedge clk);
      cnt++;
    end
    while (acc_done !== 1'b1 && cnt < 40);
  endtask : acc

  task t_cfg(input logic [15:0] v);
    logic [1:0] sp;
    wr(BUS_AREA_CONFIG_ADDR, v);
    for (int a = 0; a < 8; a++)
    begin
      req.area <= a[2:0];
      @(posedge clk);
      sp = (a == 1 && v[15]) ? 2'h1 : (a == 6 && v[14]) ? 2'h2 : 2'h0;
      chk("space", cfg.space, sp);
    end
    chk("duty", cfg.rd_duty_35, v[12]);
    chk("scheme", cfg.byte_scheme, v[11]);
    chk("overlap", cfg.overlap, v[13]);
  endtask : t_cfg

  task t_regs;
    rd(BUS_AREA_CONFIG_ADDR, 16'h0000, RESP_OKAY);
    rd(WAIT_STATE_SELECT_ADDR, 16'hffff, RESP_OKAY);
    rd(LONG_WAIT_CTRL_ADDR, 16'h7803, RESP_OKAY);
    wr(BUS_AREA_CONFIG_ADDR, 16'hffff);
    rd(BUS_AREA_CONFIG_ADDR, 16'hf800, RESP_OKAY);
    rd(4'h1, 16'h0000, RESP_SLVERR);
  endtask : t_regs

  task t_overlap;
    req <= '{1'b1, 3'h3, 1'b0, 1'b0, 1'b1};
    repeat (5)
    begin
      @(posedge clk);
      chk("blocked", req_ready, 1'b0);
    end
    // Internal traffic ends while the request is still held, so it is taken
    req.internal_busy <= 1'b0;
    @(posedge clk);
    chk("released", req_ready, 1'b1);
    req.valid <= 1'b0;
    wr(BUS_AREA_CONFIG_ADDR, 16'h2000);
    req <= '{1'b1, 3'h3, 1'b0, 1'b0, 1'b1};
    @(posedge clk);
    chk("overlapped", req_ready, 1'b1);
    req.valid <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : t_overlap

  task t_reset_waits;
    acc(3'h3, 1'b0, 1'b0, 4'h0, n);
    chk("area3 sampled", n, 3);
    acc(3'h3, 1'b0, 1'b0, 4'h3, n);
    chk("area3 stretch", n > 3, 1);
    acc(3'h0, 1'b0, 1'b0, 4'h0, n);
    chk("area0 long", n, 6);
    acc(3'h5, 1'b0, 1'b1, 4'h3, n);
    chk("refresh", n, 5);
  endtask : t_reset_waits

  task t_prog_waits;
    acc(3'h6, 1'b0, 1'b0, 4'h0, n);
    chk("mux io", n, 5);
    acc(3'h1, 1'b1, 1'b0, 4'h0, n);
    chk("dram long", n, 3);
    // Area 1 is DRAM here, so clearing its write wait is allowed
    wr(WAIT_STATE_SELECT_ADDR, 16'h2000);
    acc(3'h1, 1'b1, 1'b0, 4'h0, n);
    chk("dram short", n, 2);
    acc(3'h5, 1'b0, 1'b0, 4'h0, n);
    chk("area5 bit", n, 3);
    acc(3'h4, 1'b0, 1'b0, 4'h3, n);
    chk("area4 ignore", n, 2);
    acc(3'h0, 1'b0, 1'b0, 4'h0, n);
    chk("area0 fixed", n, 6);
    wr(LONG_WAIT_CTRL_ADDR, 16'h1803);
    acc(3'h2, 1'b0, 1'b0, 4'h0, n);
    chk("area2 short", n, 3);
  endtask : t_prog_waits

  // Strobes stand while the timer is busy, i.e. at the edge after the take
  task t_strobe(input logic [15:0] v, input logic w, input logic a0, input logic [4:0] exp);
    wr(BUS_AREA_CONFIG_ADDR, v);
    word  <= w;
    addr0 <= a0;
    req   <= '{1'b1, 3'h3, 1'b1, 1'b0, 1'b0};
    do
      @(posedge clk);
    while (req_ready !== 1'b1);
    req.valid <= 1'b0;
    @(posedge clk);
    chk("strobes", {rd_n, wr_hi_n, wr_lo_n, hb_n, lb_n}, exp);
    repeat (3) @(posedge clk);
  endtask : t_strobe

  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_cfg(16'h0000);
    t_overlap;
    t_reset_waits;
    t_cfg(16'hf800);
    t_prog_waits;
    t_strobe(16'h0800, 1'b1, 1'b0, 5'b10100);
    t_strobe(16'h0800, 1'b0, 1'b1, 5'b10110);
    t_strobe(16'h0000, 1'b0, 1'b1, 5'b11011);
    finish_test;
  end
endmodule : external_bus_area_wait_control_test
